// ===== src/acr_map.svh
// Contract
// (R01) Sixteen-input mode: converter 9 takes pair 17 when bit 11 is 0, else 18.
// (R02) Sixteen-input mode: converter 10 takes pair 19 when bit 10 is 0, else 20.
// (R03) Sixteen-input mode: converter 11 takes pair 21 when bit 9 is 0, else 22.
// (R04) Sixteen-input mode: converter 12 takes pair 23 when bit 8 is 0, else 24.
// (R05) Selector set: bits 7-5 choose the pattern code for lane 11.
// (R06) Selector set: bits 4-2 choose the pattern code for lane 12.
// (R07) Bits 15-12 power down digital sections of converters 12, 11, 10, 9.
// (R08) Bits 11-8 power down serial lanes 12, 11, 10, 9.
// (R09) Bits 7-4 power down analog sections of converters 12, 11, 10, 9.
// (R10) Bits 3-0 invert converter data on lanes 12, 11, 10, 9.
// (R11) Inversion touches converter data only, never test patterns.
// (R12) Gain enable set: odd samples of converter 13 get N times 0.2 dB.
// (R13) Offset enable set: subtract 10-bit signed bits 9-0 from odd samples.
// (R14) Offset LSB equals one LSB of a 14-bit sample at any resolution.
// (R15) Every field resets to zero, meaning normal operation.
// (R16) Software writes zero into every reserved bit.
// (R17) Selector clear: lane 11 and 12 pattern fields have no effect.
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACR_OFF_INSEL     8'h2F
`define ACR_OFF_PDN       8'h30
`define ACR_OFF_CORR13    8'h31

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACR_RST_WORD      16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACR_INSEL_HI      11
`define ACR_INSEL_LO      8
`define ACR_PAT11_HI      7
`define ACR_PAT11_LO      5
`define ACR_PAT12_HI      4
`define ACR_PAT12_LO      2
`define ACR_PDN_DIG_HI    15
`define ACR_PDN_DIG_LO    12
`define ACR_PDN_LANE_HI   11
`define ACR_PDN_LANE_LO   8
`define ACR_PDN_ANA_HI    7
`define ACR_PDN_ANA_LO    4
`define ACR_INV_HI        3
`define ACR_INV_LO        0
`define ACR_GAIN_HI       15
`define ACR_GAIN_LO       11
`define ACR_OFFS_HI       9
`define ACR_OFFS_LO       0

// ----------------------------------------
// Datapath figures
// ----------------------------------------
`define ACR_UNITY_GAIN    14'h1000
`define ACR_GAIN_SHIFT    12

`endif

// ===== src/acr_pkg.sv
package acr_pkg;

    typedef logic [13:0] acr_sample_t;
    typedef logic [2:0]  acr_pat_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } acr_bus_req_s;

    // Index 0 is converter/lane 9, index 3 is 12
    typedef struct packed {
        logic [3:0] digital;
        logic [3:0] analog;
        logic [3:0] lane;
    } acr_pdn_s;

endpackage

// ===== src/acr_lane_mux.sv
`timescale 1ns/1ps
`default_nettype none
module acr_lane_mux
    import acr_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire acr_sample_t conv_data_i [4],
    input  wire acr_sample_t pattern_data_i [4],
    input  wire logic [3:0]  pattern_on_i,
    input  wire logic [3:0]  invert_i,
    input  wire logic [3:0]  powerdown_i,
    output acr_sample_t      lane_data_o [4]
);

    // ----------------------------------------
    // Per-lane source select
    // ----------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_lane
        always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                lane_data_o[g] <= 14'h0000;
            end else if (powerdown_i[g]) begin
                // A dead lane holds still rather than toggling
                lane_data_o[g] <= 14'h0000; // R08
            end else if (pattern_on_i[g]) begin
                lane_data_o[g] <= pattern_data_i[g]; // R11
            end else if (invert_i[g]) begin
                lane_data_o[g] <= ~conv_data_i[g]; // R10
            end else begin
                lane_data_o[g] <= conv_data_i[g];
            end
        end
    end

endmodule // acr_lane_mux
`default_nettype wire

// ===== src/acr_odd_corr.sv
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"
module acr_odd_corr
    import acr_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire acr_sample_t sample_i,
    input  wire logic        valid_i,
    input  wire logic [4:0]  gain_code_i,
    input  wire logic [9:0]  offset_i,
    input  wire logic        gain_en_i,
    input  wire logic        offset_en_i,
    output acr_sample_t      sample_o,
    output logic             valid_o
);

    // ----------------------------------------
    // Gain table, 10^(N/100) in 2.12 form
    // ----------------------------------------
    localparam logic [13:0] GAIN_LUT [32] = '{
        14'h1000, 14'h105F, 14'h10C1, 14'h1125, 14'h118B, 14'h11F4, 14'h125F, 14'h12CC,
        14'h133C, 14'h13AF, 14'h1425, 14'h149D, 14'h1518, 14'h1595, 14'h1616, 14'h169A,
        14'h1721, 14'h17AA, 14'h1838, 14'h18C8, 14'h195C, 14'h19F3, 14'h1A8E, 14'h1B2C,
        14'h1BCE, 14'h1C74, 14'h1D1D, 14'h1DCB, 14'h1E7D, 14'h1F33, 14'h1FED, 14'h20AB
    };

    logic signed [14:0] diff_reg;
    logic        [13:0] mult_reg;
    logic               v1_reg;
    logic signed [29:0] prod;
    logic signed [17:0] scaled;

    // ----------------------------------------
    // Stage 1: offset, 14-bit LSB weight
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            diff_reg <= 15'h0000;
            mult_reg <= `ACR_UNITY_GAIN;
            v1_reg   <= 1'b0;
        end else begin
            v1_reg   <= valid_i;
            if (offset_en_i) begin
                diff_reg <= $signed({sample_i[13], sample_i})
                          - $signed({{5{offset_i[9]}}, offset_i}); // R13 R14
            end else begin
                diff_reg <= $signed({sample_i[13], sample_i});
            end
            mult_reg <= gain_en_i ? GAIN_LUT[gain_code_i] : `ACR_UNITY_GAIN; // R12
        end
    end

    // ----------------------------------------
    // Stage 2: gain and saturation
    // ----------------------------------------
    always_comb begin
        prod   = diff_reg * $signed({1'b0, mult_reg});
        scaled = prod[29:12];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_o <= 14'h0000;
            valid_o  <= 1'b0;
        end else begin
            valid_o <= v1_reg;
            // Clip instead of wrap so large gains never flip sign
            if (scaled > 18'sh01FFF) begin
                sample_o <= 14'h1FFF;
            end else if (scaled < -18'sh02000) begin
                sample_o <= 14'h2000;
            end else begin
                sample_o <= scaled[13:0];
            end
        end
    end

endmodule // acr_odd_corr
`default_nettype wire

// ===== src/acr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"
module acr_regs
    import acr_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire acr_bus_req_s bus_i,
    output logic [15:0]       rdata_o,
    input  wire logic         sixteen_input_mode_i,
    input  wire logic         per_lane_pattern_selector_i,
    input  wire logic         global_digital_gain_enable_i,
    input  wire logic         global_digital_offset_enable_i,
    output logic [3:0]        input_pair_select_o,
    output acr_pdn_s          pdn_o,
    output acr_pat_t          lane11_pattern_code_o,
    output acr_pat_t          lane12_pattern_code_o,
    output logic              lane_pattern_codes_valid_o,
    input  wire acr_sample_t  conv_data_i [4],
    input  wire acr_sample_t  pattern_data_i [4],
    input  wire logic [3:0]   pattern_on_i,
    output acr_sample_t       lane_data_o [4],
    input  wire acr_sample_t  conv13_sample_i,
    input  wire logic         conv13_odd_valid_i,
    output acr_sample_t       conv13_corr_o,
    output logic              conv13_corr_valid_o
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [15:0] input_select_and_lane_pattern_reg;
    logic [15:0] power_down_and_inversion_reg;
    logic [15:0] odd_sample_gain_offset_13_reg;

    logic        hit_insel;
    logic        hit_pdn;
    logic        hit_corr;
    logic [15:0] rdata_next;

    logic        input_pair_select_conv9;
    logic        input_pair_select_conv10;
    logic        input_pair_select_conv11;
    logic        input_pair_select_conv12;
    acr_pat_t    lane11_pattern_code;
    acr_pat_t    lane12_pattern_code;
    logic [3:0]  lane_data_invert;
    logic [3:0]  lane_powerdown;
    logic [3:0]  digital_powerdown;
    logic [3:0]  analog_powerdown;
    logic [4:0]  odd_sample_gain_conv13;
    logic [9:0]  odd_sample_offset_conv13;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    always_comb begin
        hit_insel = (bus_i.addr == `ACR_OFF_INSEL);
        hit_pdn   = (bus_i.addr == `ACR_OFF_PDN);
        hit_corr  = (bus_i.addr == `ACR_OFF_CORR13);
    end

    // ----------------------------------------
    // Writes, one register per process
    // ----------------------------------------
    // Reserved bits are stored as written so a read shows any misuse
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_select_and_lane_pattern_reg <= `ACR_RST_WORD; // R15
        end else if (bus_i.wr && hit_insel) begin
            input_select_and_lane_pattern_reg <= bus_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_down_and_inversion_reg <= `ACR_RST_WORD; // R15
        end else if (bus_i.wr && hit_pdn) begin
            power_down_and_inversion_reg <= bus_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            odd_sample_gain_offset_13_reg <= `ACR_RST_WORD; // R15
        end else if (bus_i.wr && hit_corr) begin
            odd_sample_gain_offset_13_reg <= bus_i.wdata;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rdata_next = 16'h0000;
        if (bus_i.rd) begin
            unique case (1'b1)
                hit_insel: begin
                    rdata_next = input_select_and_lane_pattern_reg;
                end
                hit_pdn: begin
                    rdata_next = power_down_and_inversion_reg;
                end
                hit_corr: begin
                    rdata_next = odd_sample_gain_offset_13_reg;
                end
                default: begin
                    // Unmapped offsets read as zero
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    always_comb begin
        input_pair_select_conv9  = input_select_and_lane_pattern_reg[`ACR_INSEL_HI];
        input_pair_select_conv10 = input_select_and_lane_pattern_reg[`ACR_INSEL_HI - 1];
        input_pair_select_conv11 = input_select_and_lane_pattern_reg[`ACR_INSEL_LO + 1];
        input_pair_select_conv12 = input_select_and_lane_pattern_reg[`ACR_INSEL_LO];
        lane11_pattern_code =
            input_select_and_lane_pattern_reg[`ACR_PAT11_HI:`ACR_PAT11_LO];
        lane12_pattern_code =
            input_select_and_lane_pattern_reg[`ACR_PAT12_HI:`ACR_PAT12_LO];
    end

    // Register order runs 12 down to 9; vectors here run 9 up to 12
    for (genvar g = 0; g < 4; g++) begin : g_unpack
        assign digital_powerdown[g] =
            power_down_and_inversion_reg[`ACR_PDN_DIG_LO + g];
        assign lane_powerdown[g] =
            power_down_and_inversion_reg[`ACR_PDN_LANE_LO + g];
        assign analog_powerdown[g] =
            power_down_and_inversion_reg[`ACR_PDN_ANA_LO + g];
        assign lane_data_invert[g] =
            power_down_and_inversion_reg[`ACR_INV_LO + g];
    end

    always_comb begin
        odd_sample_gain_conv13 =
            odd_sample_gain_offset_13_reg[`ACR_GAIN_HI:`ACR_GAIN_LO];
        odd_sample_offset_conv13 =
            odd_sample_gain_offset_13_reg[`ACR_OFFS_HI:`ACR_OFFS_LO];
    end

    // ----------------------------------------
    // Input pair routing
    // ----------------------------------------
    // Outside sixteen-input mode the lower pair is presented, the safe default
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_pair_select_o <= 4'h0;
        end else if (sixteen_input_mode_i) begin
            input_pair_select_o[0] <= input_pair_select_conv9;  // R01
            input_pair_select_o[1] <= input_pair_select_conv10; // R02
            input_pair_select_o[2] <= input_pair_select_conv11; // R03
            input_pair_select_o[3] <= input_pair_select_conv12; // R04
        end else begin
            input_pair_select_o <= 4'h0;
        end
    end

    // ----------------------------------------
    // Power-down controls
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pdn_o.digital <= 4'h0;
        end else begin
            pdn_o.digital <= digital_powerdown; // R07
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pdn_o.lane <= 4'h0;
        end else begin
            pdn_o.lane <= lane_powerdown; // R08
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pdn_o.analog <= 4'h0;
        end else begin
            pdn_o.analog <= analog_powerdown; // R09
        end
    end

    // ----------------------------------------
    // Lane pattern codes
    // ----------------------------------------
    // Codes are masked to zero while the selector is clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lane11_pattern_code_o <= 3'h0;
            lane12_pattern_code_o <= 3'h0;
            lane_pattern_codes_valid_o <= 1'b0;
        end else if (per_lane_pattern_selector_i) begin
            lane11_pattern_code_o <= lane11_pattern_code; // R05
            lane12_pattern_code_o <= lane12_pattern_code; // R06
            lane_pattern_codes_valid_o <= 1'b1;
        end else begin
            lane11_pattern_code_o <= 3'h0; // R17
            lane12_pattern_code_o <= 3'h0; // R17
            lane_pattern_codes_valid_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Lane datapath
    // ----------------------------------------
    acr_lane_mux u_lane_mux (
        .ref_clk_i      (ref_clk_i),
        .rst_n_i        (rst_n_i),
        .conv_data_i    (conv_data_i),
        .pattern_data_i (pattern_data_i),
        .pattern_on_i   (pattern_on_i),
        .invert_i       (lane_data_invert),
        .powerdown_i    (lane_powerdown),
        .lane_data_o    (lane_data_o)
    );

    // ----------------------------------------
    // Converter 13 odd-sample correction
    // ----------------------------------------
    // Two-stage pipeline trades latency for a short multiplier path
    acr_odd_corr u_odd_corr (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .sample_i    (conv13_sample_i),
        .valid_i     (conv13_odd_valid_i),
        .gain_code_i (odd_sample_gain_conv13),
        .offset_i    (odd_sample_offset_conv13),
        .gain_en_i   (global_digital_gain_enable_i),
        .offset_en_i (global_digital_offset_enable_i),
        .sample_o    (conv13_corr_o),
        .valid_o     (conv13_corr_valid_o)
    );

endmodule // acr_regs
`default_nettype wire

// ===== testbench/acr_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module acr_regs_checker
    import acr_pkg::*;
(
    input wire logic         ref_clk_i,
    input wire logic         rst_n_i,
    input wire logic         sixteen_input_mode_i,
    input wire logic         per_lane_pattern_selector_i,
    input wire logic         global_digital_gain_enable_i,
    input wire logic         global_digital_offset_enable_i,
    input wire logic [3:0]   input_pair_select_o,
    input wire acr_pdn_s     pdn_o,
    input wire acr_pat_t     lane11_pattern_code_o,
    input wire acr_pat_t     lane12_pattern_code_o,
    input wire logic         lane_pattern_codes_valid_o,
    input wire acr_sample_t  pattern_data_i [4],
    input wire logic [3:0]   pattern_on_i,
    input wire acr_sample_t  lane_data_o [4],
    input wire acr_sample_t  conv13_sample_i,
    input wire logic         conv13_odd_valid_i,
    input wire acr_sample_t  conv13_corr_o,
    input wire logic         conv13_corr_valid_o
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // Mux may use the register bit or pdn_o, so both must agree before judging
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_reset_clear: assert property ($rose(rst_n_i) |-> pdn_o == '0 &&
        input_pair_select_o == 4'h0 && lane11_pattern_code_o == 3'h0)
        else $error("outputs not clear after reset");
    a_insel_mode: assert property (!$past(sixteen_input_mode_i) |->
        input_pair_select_o == 4'h0) else $error("pair select outside mode");
    a_codes_gated: assert property (!$past(per_lane_pattern_selector_i) |->
        lane11_pattern_code_o == 3'h0 && lane12_pattern_code_o == 3'h0)
        else $error("pattern code leaks while selector clear");
    a_codes_valid: assert property ($past(rst_n_i) |->
        lane_pattern_codes_valid_o == $past(per_lane_pattern_selector_i))
        else $error("code valid not a delayed selector");
    a_pattern_pass: assert property ($past(rst_n_i) && $past(pattern_on_i[2]) &&
        !pdn_o.lane[2] && !$past(pdn_o.lane[2]) |-> lane_data_o[2] == $past(pattern_data_i[2]))
        else $error("pattern altered on lane");
    a_lane_down: assert property (pdn_o.lane[0] && $past(pdn_o.lane[0]) |->
        lane_data_o[0] == 14'h0000) else $error("powered down lane drives data");
    a_corr_bypass: assert property ($past(conv13_odd_valid_i, 2) &&
        !$past(global_digital_gain_enable_i, 2) && !$past(global_digital_offset_enable_i, 2)
        |-> conv13_corr_o == $past(conv13_sample_i, 2)) else $error("sample changed");
    a_corr_valid: assert property ($past(rst_n_i, 2) |->
        conv13_corr_valid_o == $past(conv13_odd_valid_i, 2)) else $error("valid delay wrong");
endmodule // acr_regs_checker

bind acr_regs acr_regs_checker chk_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sixteen_input_mode_i(sixteen_input_mode_i),
    .per_lane_pattern_selector_i(per_lane_pattern_selector_i),
    .global_digital_gain_enable_i(global_digital_gain_enable_i),
    .global_digital_offset_enable_i(global_digital_offset_enable_i),
    .input_pair_select_o(input_pair_select_o), .pdn_o(pdn_o),
    .lane11_pattern_code_o(lane11_pattern_code_o), .lane12_pattern_code_o(lane12_pattern_code_o),
    .lane_pattern_codes_valid_o(lane_pattern_codes_valid_o), .pattern_data_i(pattern_data_i),
    .pattern_on_i(pattern_on_i), .lane_data_o(lane_data_o), .conv13_sample_i(conv13_sample_i),
    .conv13_odd_valid_i(conv13_odd_valid_i), .conv13_corr_o(conv13_corr_o),
    .conv13_corr_valid_o(conv13_corr_valid_o));
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acr_pkg::*;
    logic         ref_clk_i = 1'b0;
    logic         rst_n_i   = 1'b0;
    acr_bus_req_s bus       = '0;
    logic [15:0]  rdata;
    logic [15:0]  w;
    logic         mode = 1'b0, sel = 1'b0, ge = 1'b0, oe = 1'b0, v13 = 1'b0;
    logic [3:0]   insel, pat_on = 4'h0;
    acr_pdn_s     pdn;
    acr_pat_t     code11, code12;
    logic         codes_vld, corr_v;
    acr_sample_t  conv [4] = '{default: 14'h0000};
    acr_sample_t  pat [4] = '{default: 14'h0000};
    acr_sample_t  lane [4];
    acr_sample_t  s13 = 14'h0000, corr;
    int           fails = 0, total_checks = 0, cycles = 0;
    int           cs [7] = '{100, 100, 1000, -100, 7936, -8000, 100};
    int           co [7] = '{4, -5, 0, 0, 0, 300, 4};
    int           cn [7] = '{0, 0, 31, 10, 31, 5, 31};
    logic [1:0]   ce [7] = '{2'b01, 2'b01, 2'b10, 2'b10, 2'b10, 2'b11, 2'b00};

    acr_regs dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
        .sixteen_input_mode_i(mode), .per_lane_pattern_selector_i(sel),
        .global_digital_gain_enable_i(ge), .global_digital_offset_enable_i(oe),
        .input_pair_select_o(insel), .pdn_o(pdn), .lane11_pattern_code_o(code11),
        .lane12_pattern_code_o(code12), .lane_pattern_codes_valid_o(codes_vld),
        .conv_data_i(conv), .pattern_data_i(pat), .pattern_on_i(pat_on), .lane_data_o(lane),
        .conv13_sample_i(s13), .conv13_odd_valid_i(v13), .conv13_corr_o(corr),
        .conv13_corr_valid_o(corr_v));

    // ----------------------------------------
    // Clock, watchdog and bus tasks
    // ----------------------------------------
    always #12.5 ref_clk_i = ~ref_clk_i;

    task automatic results();
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Whole run needs about 185 cycles; a hang is cut well after that
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Each task starts on a fresh edge, so a strobe never drops and rises in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk_i);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge ref_clk_i);
        bus.rd <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk_clear();
        rd(8'h2F, 16'h0000);
        rd(8'h30, 16'h0000);
        rd(8'h31, 16'h0000);
        chk("pdn", 16'h0000, 16'(pdn));
        chk("codes", 16'h0000, {10'h000, code11, code12});
    endtask

    task automatic chk_lanes(input logic [3:0] pd, input logic [3:0] inv);
        logic [13:0] e;
        for (int k = 0; k < 4; k++) begin
            e = pd[k] ? 14'h0000 : pat_on[k] ? pat[k] : inv[k] ? ~conv[k] : conv[k];
            chk("lane", 16'(e), 16'(lane[k]));
        end
    endtask

    function automatic logic [13:0] corr_exp(input int s, input int o, input int n,
                                             input logic [1:0] en);
        longint v;
        int     lut;
        lut = en[1] ? $rtoi($pow(10.0, n / 100.0) * 4096.0 + 0.5) : 4096;
        v = longint'(s - (en[0] ? o : 0)) * lut;
        v = v >>> 12;
        if (v > 8191) v = 8191;
        if (v < -8192) v = -8192;
        return v[13:0];
    endfunction

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        chk_clear();
        wr(8'h2E, 16'h1234);
        rd(8'h2E, 16'h0000);
        rd(8'h32, 16'h0000);
        @(posedge ref_clk_i);
        mode <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(8'h2F, (16'h0800 >> k) | 16'h00AC);
            settle();
            chk("pair select", 16'(4'h1 << k), {12'h000, insel});
            chk("codes idle", 16'h0000, {10'h000, code11, code12});
        end
        @(posedge ref_clk_i);
        sel <= 1'b1;
        settle();
        chk("codes", 16'h006B, {9'h000, codes_vld, code11, code12});
        rd(8'h2F, 16'h01AC);
        for (int i = 4; i < 16; i++) begin
            w = 16'h0001 << i;
            wr(8'h30, w);
            settle();
            chk("pdn", 16'({w[15:12], w[7:4], w[11:8]}), 16'(pdn));
        end
        @(posedge ref_clk_i);
        pat_on <= 4'b0101;
        for (int k = 0; k < 4; k++) begin
            conv[k] <= 14'(16'h0155 * (k + 1));
            pat[k]  <= 14'(16'h2A00 + k);
        end
        wr(8'h30, 16'h0006);
        settle();
        chk_lanes(4'h0, 4'h6);
        wr(8'h30, 16'h0306);
        settle();
        chk_lanes(4'h3, 4'h6);
        for (int j = 0; j < 7; j++) begin
            wr(8'h31, {cn[j][4:0], 1'b0, co[j][9:0]});
            rd(8'h31, {cn[j][4:0], 1'b0, co[j][9:0]});
            @(posedge ref_clk_i);
            s13 <= 14'(cs[j]);
            v13 <= 1'b1;
            ge  <= ce[j][1];
            oe  <= ce[j][0];
            @(posedge ref_clk_i);
            v13 <= 1'b0;
            @(posedge ref_clk_i);
            #1 chk("corr", 16'(corr_exp(cs[j], co[j], cn[j], ce[j])), 16'(corr));
            chk("corr valid", 16'h0001, 16'(corr_v));
        end
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        chk_clear();
        chk_lanes(4'h0, 4'h0);
        results();
    end
endmodule // tb
`default_nettype wire
